// *** err_clear_enc_div.sv ***
// error counter clear and divided encoder pulse output
`timescale 1ns/10ps
// Operation
// R1: active clear condition forces error counter zero
// R2: position loop inhibited while counter held cleared
// R3: form 0 holds cleared while input high
// R4: form 1 clears once per rising edge
// R5: form 2 holds cleared while input low
// R6: form 3 clears once per falling edge
// R7: host holds clear at least 20 us
// R8: phases A, B, C out as true/complement
// R9: A/B carry programmed pulses per revolution
// R10: divider independent of electronic gear
// R11: divider range set by encoder resolution
// R12: 13-bit encoder caps output at 2048
// R13: divider change takes effect after power cycle
// R14: host turns motor before using phase C
// R15: A/B quadrature by direction, one C/rev
module err_clear_enc_div
    import pos_if_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             error_clear_in_i,
    input  wire logic             error_clear_in_n_i,
    input  wire logic [1:0]       clear_form_select_i,
    input  wire logic [DIV_W-1:0] output_divider_setting_i,
    input  wire logic [1:0]       enc_resolution_i,
    input  wire logic             enc_a_i,
    input  wire logic             enc_b_i,
    input  wire logic             enc_index_i,
    input  wire logic             ref_up_i,
    input  wire logic             ref_down_i,
    output logic [ERR_W-1:0]      error_count_o,
    output logic                  position_loop_enable_o,
    output logic                  div_phase_a_out_o,
    output logic                  div_phase_a_out_n_o,
    output logic                  div_phase_b_out_o,
    output logic                  div_phase_b_out_n_o,
    output logic                  div_phase_c_out_o,
    output logic                  div_phase_c_out_n_o
);
    enc_step_if fb ();

    quad_decoder u_dec (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_n_i),
        .a_i     (enc_a_i),
        .b_i     (enc_b_i),
        .stp     (fb.src)
    );

    // ---------------- error counter clear ----------------
    logic clr_lvl;
    logic clr_prev_r;
    logic clr_hold;
    logic clr_now;

    // clear level is high only when the true line is high and the complement line is low
    assign clr_lvl = error_clear_in_i & ~error_clear_in_n_i;
    assign clr_hold =
        (clear_form_select_i == CLR_LEVEL_HIGH &&  clr_lvl) || // R3
        (clear_form_select_i == CLR_LEVEL_LOW  && !clr_lvl);   // R5
    assign clr_now = clr_hold ||
        (clear_form_select_i == CLR_EDGE_RISE &&
          clr_lvl && !clr_prev_r) ||                           // R4
        (clear_form_select_i == CLR_EDGE_FALL &&
         !clr_lvl &&  clr_prev_r);                             // R6

    logic [ERR_W-1:0] err_r;
    logic [ERR_W-1:0] err_nxt;
    logic [ERR_W-1:0] ref_delta;
    logic [ERR_W-1:0] fb_delta;

    assign ref_delta = (ref_up_i && !ref_down_i) ? 24'h000001 :
                       (ref_down_i && !ref_up_i) ? 24'hffffff : ERR_ZERO;
    assign fb_delta  = !fb.step ? ERR_ZERO :
                       fb.dir ? 24'hffffff : 24'h000001;
    assign err_nxt   = clr_now ? ERR_ZERO                       // R1
                               : err_r + ref_delta + fb_delta;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clr_prev_r <= 1'b0;
            err_r      <= ERR_ZERO;
            position_loop_enable_o <= 1'b0;
        end else begin
            clr_prev_r <= clr_lvl;
            err_r      <= err_nxt;
            position_loop_enable_o <= !clr_hold;               // R2
        end
    end

    assign error_count_o = err_r;

    // ---------------- divider setting capture ----------------
    logic             loaded_r;
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] div_cap;
    logic [DIV_W-1:0] div_max;
    logic [ACC_W-1:0] native_ppr;

    assign div_max = (enc_resolution_i == ENC_13BIT) ? DIV_MAX_13
                                                     : DIV_MAX_HI; // R11
    // above range clamps to max, 2048 on 13-bit
    assign div_cap =
        (output_divider_setting_i < DIV_MIN) ? DIV_MIN :
        (output_divider_setting_i > div_max) ? div_max :     // R12
        output_divider_setting_i;
    assign native_ppr = (enc_resolution_i == ENC_13BIT) ? PPR_13BIT :
                        (enc_resolution_i == ENC_16BIT) ? PPR_16BIT :
                        PPR_17BIT;

    // taken once after reset release only
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loaded_r <= 1'b0;
            div_r    <= DIV_DEFAULT;
        end else if (!loaded_r) begin
            loaded_r <= 1'b1;
            div_r    <= div_cap;                                // R13
        end
    end

    // ---------------- pulse divider ----------------
    // gear inputs deliberately not used here  R10
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_nxt;
    logic [ACC_W-1:0] acc_up;
    logic [ACC_W-1:0] acc_dn;
    logic [ACC_W-1:0] div_ext;
    logic             out_fwd;
    logic             out_rev;
    logic [1:0]       ph_r;
    logic [1:0]       ph_nxt;

    assign div_ext = {{(ACC_W-DIV_W){1'b0}}, div_r};
    assign acc_up  = acc_r + div_ext;
    assign acc_dn  = acc_r - div_ext;
    assign out_fwd = loaded_r && fb.step &&  fb.dir &&
                     (acc_up >= native_ppr);                    // R9
    assign out_rev = loaded_r && fb.step && !fb.dir &&
                     (acc_r < div_ext);
    assign acc_nxt = !(loaded_r && fb.step) ? acc_r :
                     fb.dir ? (out_fwd ? acc_up - native_ppr : acc_up)
                            : (out_rev ? acc_dn + native_ppr : acc_dn);
    assign ph_nxt  = out_fwd ? ph_r + 2'h1 :
                     out_rev ? ph_r - 2'h1 : ph_r;              // R15

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_r <= ACC_ZERO;
            ph_r  <= PHASE_ZERO;
        end else begin
            acc_r <= acc_nxt;
            ph_r  <= ph_nxt;
        end
    end

    // a leads b when counting up
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_phase_a_out_o   <= 1'b0;
            div_phase_a_out_n_o <= 1'b1;
            div_phase_b_out_o   <= 1'b0;
            div_phase_b_out_n_o <= 1'b1;
            div_phase_c_out_o   <= 1'b0;
            div_phase_c_out_n_o <= 1'b1;
        end else begin
            div_phase_a_out_o   <=   ph_nxt[1] ^ ph_nxt[0];     // R8
            div_phase_a_out_n_o <= ~(ph_nxt[1] ^ ph_nxt[0]);
            div_phase_b_out_o   <=   ph_nxt[1];
            div_phase_b_out_n_o <=  ~ph_nxt[1];
            div_phase_c_out_o   <=   enc_index_i;               // R15
            div_phase_c_out_n_o <=  ~enc_index_i;
        end
    end
endmodule : err_clear_enc_div

// *** pos_if_pkg.sv ***
// constants for error clear and divided encoder output logic
package pos_if_pkg;
    localparam int ERR_W   = 24;
    localparam int DIV_W   = 15;
    localparam int ACC_W   = 18;

    // clear form codes
    localparam logic [1:0] CLR_LEVEL_HIGH = 2'h0;
    localparam logic [1:0] CLR_EDGE_RISE  = 2'h1;
    localparam logic [1:0] CLR_LEVEL_LOW  = 2'h2;
    localparam logic [1:0] CLR_EDGE_FALL  = 2'h3;

    // encoder resolution codes
    localparam logic [1:0] ENC_13BIT = 2'h0;
    localparam logic [1:0] ENC_16BIT = 2'h1;

    // native pulses per revolution
    localparam logic [ACC_W-1:0] PPR_13BIT = 18'h00800;
    localparam logic [ACC_W-1:0] PPR_16BIT = 18'h04000;
    localparam logic [ACC_W-1:0] PPR_17BIT = 18'h08000;

    // divider limits and reset value
    localparam logic [DIV_W-1:0] DIV_MIN      = 15'h0010;
    localparam logic [DIV_W-1:0] DIV_MAX_13   = 15'h0800;
    localparam logic [DIV_W-1:0] DIV_MAX_HI   = 15'h4000;
    localparam logic [DIV_W-1:0] DIV_DEFAULT  = 15'h4000;

    localparam logic [ERR_W-1:0] ERR_ZERO     = 24'h000000;
    localparam logic [ACC_W-1:0] ACC_ZERO     = 18'h00000;
    localparam logic [1:0]       PHASE_ZERO   = 2'h0;
endpackage : pos_if_pkg

// *** enc_step_if.sv ***
// step and direction from encoder decoder to divider
`timescale 1ns/10ps
interface enc_step_if;
    logic step;
    logic dir;
    modport src (output step, output dir);
    modport dst (input step, input dir);
endinterface : enc_step_if

// *** quad_decoder.sv ***
// quadrature decoder: one step per encoder edge with direction
`timescale 1ns/10ps
module quad_decoder
    import pos_if_pkg::*;
(
    input  wire logic    clk_i,
    input  wire logic    rst_n_i,
    input  wire logic    a_i,
    input  wire logic    b_i,
    enc_step_if.src      stp
);
    logic [1:0] prev_r;
    logic [1:0] cur;
    logic       fwd;
    logic       rev;

    assign cur = {a_i, b_i};
    // a leads b for forward rotation
    assign fwd = (prev_r == 2'h0 && cur == 2'h2) ||
                 (prev_r == 2'h2 && cur == 2'h3) ||
                 (prev_r == 2'h3 && cur == 2'h1) ||
                 (prev_r == 2'h1 && cur == 2'h0);
    assign rev = (prev_r == 2'h0 && cur == 2'h1) ||
                 (prev_r == 2'h1 && cur == 2'h3) ||
                 (prev_r == 2'h3 && cur == 2'h2) ||
                 (prev_r == 2'h2 && cur == 2'h0);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_r   <= PHASE_ZERO;
            stp.step <= 1'b0;
            stp.dir  <= 1'b0;
        end else begin
            prev_r   <= cur;
            stp.step <= fwd | rev;
            stp.dir  <= fwd;
        end
    end
endmodule : quad_decoder

// *** ecd_monitor.sv ***
// assertions on clear forms and divided encoder outputs
`timescale 1ns/10ps
module ecd_monitor import pos_if_pkg::*; (
    input wire logic             core_clk_i,
    input wire logic             rst_n_i,
    input wire logic             error_clear_in_i,
    input wire logic             error_clear_in_n_i,
    input wire logic [1:0]       clear_form_select_i,
    input wire logic [ERR_W-1:0] error_count_o,
    input wire logic             position_loop_enable_o,
    input wire logic             div_phase_a_out_o,
    input wire logic             div_phase_a_out_n_o,
    input wire logic             div_phase_b_out_o,
    input wire logic             div_phase_b_out_n_o,
    input wire logic             div_phase_c_out_o,
    input wire logic             div_phase_c_out_n_o
);
    wire       lv = error_clear_in_i & ~error_clear_in_n_i;
    wire [1:0] fm = clear_form_select_i;
    wire       zr = (error_count_o == ERR_ZERO);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_pair_a: assert property (div_phase_a_out_n_o == !div_phase_a_out_o)
        else $error("phase a pair not complementary");
    chk_pair_b: assert property (div_phase_b_out_n_o == !div_phase_b_out_o)
        else $error("phase b pair not complementary");
    chk_pair_c: assert property (div_phase_c_out_n_o == !div_phase_c_out_o)
        else $error("phase c pair not complementary");
    chk_high_hold: assert property (fm == 2'h0 && lv |=> zr)
        else $error("count not held at zero while clear high");
    chk_low_hold: assert property (fm == 2'h2 && !lv |=> zr)
        else $error("count not held at zero while clear low");
    chk_loop_off: assert property ((fm == 2'h0 && lv) || (fm == 2'h2 && !lv)
        |=> !position_loop_enable_o)
        else $error("loop enabled while count held cleared");
    chk_rise_once: assert property (fm == 2'h1 && $rose(lv) |=> zr)
        else $error("rising clear edge did not clear count");
    chk_fall_once: assert property (fm == 2'h3 && $fell(lv) |=> zr)
        else $error("falling clear edge did not clear count");
    chk_edge_keep: assert property (fm[0] |=> position_loop_enable_o)
        else $error("edge form dropped loop enable");
    chk_quad_step: assert property (!($changed(div_phase_a_out_o) &&
        $changed(div_phase_b_out_o)))
        else $error("phase a and b changed together");
    cover property (fm == 2'h1 && $rose(lv));
    cover property (fm == 2'h3 && $fell(lv));
    cover property ($rose(div_phase_c_out_o));
endmodule : ecd_monitor

// *** host_pos_model.sv ***
// host controller model: counts divided quadrature into a position
`timescale 1ns/10ps
module host_pos_model (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         pa_i,
    input  wire logic         pb_i,
    output logic signed [31:0] pos_o
);
    logic pa_r;
    logic pb_r;
    wire  fwd = (pa_r == pb_i);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pa_r <= 1'b0;
            pb_r <= 1'b0;
            pos_o <= 32'sh0;
        end else begin
            pa_r <= pa_i;
            pb_r <= pb_i;
            if ((pa_r ^ pa_i) | (pb_r ^ pb_i)) pos_o <= fwd ? pos_o + 1 : pos_o - 1;
        end
    end
endmodule : host_pos_model

// *** error_clear_and_encoder_divider_tb_top.sv ***
// bench for error clear forms and divided encoder outputs
`timescale 1ns/10ps
`define CMP(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module error_clear_and_encoder_divider_tb_top import pos_if_pkg::*;;
    logic             clk = 1'b0, rst_n = 1'b0, cl = 1'b0, cl_n = 1'b1;
    logic             ea = 1'b0, eb = 1'b0, idx = 1'b0, up = 1'b0;
    logic [1:0]       form = 2'h0, res = 2'h1;
    logic [DIV_W-1:0] dv = 15'h1000;
    logic [ERR_W-1:0] err;
    logic             en, pa, pan, pb, pbn, pc, pcn;
    logic [31:0]      pos;
    logic [1:0]       gray [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int               err_total = 0, samples_checked = 0, cyc = 0, ph = 0;
    typedef struct {int k; logic [31:0] v;} note_t;
    note_t            q[$];
    event             chk_ev;
    err_clear_enc_div dut_u (.core_clk_i(clk), .rst_n_i(rst_n),
        .error_clear_in_i(cl), .error_clear_in_n_i(cl_n),
        .clear_form_select_i(form), .output_divider_setting_i(dv),
        .enc_resolution_i(res), .enc_a_i(ea), .enc_b_i(eb),
        .enc_index_i(idx), .ref_up_i(up), .ref_down_i(1'b0),
        .error_count_o(err), .position_loop_enable_o(en),
        .div_phase_a_out_o(pa), .div_phase_a_out_n_o(pan),
        .div_phase_b_out_o(pb), .div_phase_b_out_n_o(pbn),
        .div_phase_c_out_o(pc), .div_phase_c_out_n_o(pcn));
    host_pos_model host_u (.clk_i(clk), .rst_n_i(rst_n), .pa_i(pa),
        .pb_i(pb), .pos_o(pos));
    initial forever #25 clk = ~clk;
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic expect_v(int k, logic [31:0] v);
        @(negedge clk);
        q.push_back('{k, v});
        ->chk_ev;
    endtask : expect_v
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        {ea, eb} <= 2'h0;
        ph = 0;
        tick(8);
        rst_n <= 1'b1;
        tick(2);
    endtask : do_reset
    task automatic drive_clear(logic v);
        @(posedge clk);
        cl <= v;
        cl_n <= ~v;
    endtask : drive_clear
    task automatic refs(int n);
        repeat (n) begin
            @(posedge clk) up <= 1'b1;
            @(posedge clk) up <= 1'b0;
        end
    endtask : refs
    task automatic enc(int n, int d);
        repeat (n) begin
            ph = (ph + d) & 3;
            @(posedge clk) {ea, eb} <= gray[ph];
            @(posedge clk);
        end
    endtask : enc
    task automatic stop_test();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    always begin : watch
        note_t       n;
        logic [31:0] g;
        @(chk_ev);
        n = q.pop_front();
        g = (n.k == 0) ? 32'(err) : (n.k == 1) ? 32'(en) : (n.k == 2) ? pos
            : {26'h0, pa, pan, pb, pbn, pc, pcn};
        `CMP(g, n.v)
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin : main
        int               n1, n2, act, nat, eff;
        logic [1:0]       rt [3] = '{2'h1, 2'h0, 2'h2};
        logic [DIV_W-1:0] dt [3] = '{15'h1000, 15'h4000, 15'h0010};
        int               et [3] = '{64, 0, 2048};
        void'($urandom(49));
        et[1] = $urandom_range(40, 8);
        do_reset();
        expect_v(3, 32'h15);
        @(posedge clk) idx <= 1'b1;
        tick(2);
        expect_v(3, 32'h16);
        @(posedge clk) idx <= 1'b0;
        for (int f = 0; f < 4; f++) begin
            @(posedge clk) form <= 2'(f);
            do_reset();
            act = (f < 2);
            n1 = $urandom_range(15, 1);
            n2 = $urandom_range(15, 1);
            drive_clear(!act);
            refs(n1);
            tick(2);
            expect_v(0, n1);
            drive_clear(act[0]);
            refs(n2);
            tick(400 - 2 * n2);
            expect_v(0, f[0] ? n2 : 0);
            expect_v(1, f[0]);
            drive_clear(!act);
            refs(n1);
            tick(2);
            expect_v(0, f[0] ? n1 + n2 : n1);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) res <= rt[i];
            dv <= dt[i];
            do_reset();
            nat = (rt[i] == 2'h0) ? 2048 : (rt[i] == 2'h1) ? 16384 : 32768;
            eff = (rt[i] == 2'h0 && dt[i] > 2048) ? 2048 : dt[i];
            enc(et[i], 1);
            tick(4);
            expect_v(2, et[i] * eff / nat);
            if (i == 0) begin
                @(posedge clk) dv <= 15'h4000;
                enc(64, 3);
                tick(4);
                expect_v(2, 0);
            end
        end
        tick(2);
        stop_test();
    end
endmodule : error_clear_and_encoder_divider_tb_top
bind err_clear_enc_div ecd_monitor mon_u (.*);
